// [rtl/rsc_cfg.svh]
// Purpose: Constants for the reset source combiner.
// Assumes: Wishbone classic slave, 32-bit data, word aligned registers.
// Notes: Offsets are byte addresses.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_ADDR_W 4
`define RSC_OFS_CAUSE 4'h0
`define RSC_OFS_CLKSEL 4'h4
`define RSC_BIT_TRAP 15
`define RSC_BIT_ILLOP 14
`define RSC_BIT_FREG 11
`define RSC_BIT_CM 9
`define RSC_BIT_CREG 8
`define RSC_BIT_PIN 7
`define RSC_BIT_SOFT 6
`define RSC_BIT_WDEN 5
`define RSC_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RSC_BIT_SLEEP 3
`define RSC_BIT_IDLE 2
`define RSC_BIT_BOR 1
`define RSC_BIT_POR 0
`define RSC_CAUSE_IMPL 16'hcbff
`define RSC_CAUSE_POR_VAL 16'h0003
`define RSC_RESET_HOLD 4'h3
`endif

// [rtl/rsc_pkg.sv]
// Purpose: Types for the reset source combiner.
// Assumes: Nothing beyond the constants header.
// Notes: Sequencer states only.
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_RUN = 2'b00,
        RSC_HOLD = 2'b01
    } rsc_state_type;
endpackage

// [rtl/rsc_combiner.sv]
// Purpose: Combine reset sources, record the cause, pick clock source.
// Assumes: Source inputs are asynchronous levels; pulses last 2+ clocks.
// Notes: The rules that this block carries out follow.
// Function
// R1 - Any active source asserts master system reset.
// R2 - Each reset sets its matching cause bit.
// R3 - Power-on clears all, sets bits one, zero.
// R4 - Software sets or clears bits, never resets.
// R5 - Power-on or brown-out: cold, config clock select.
// R6 - Other resets warm, current clock select used.
// R7 - Bit 15 flags trap conflict reset.
// R8 - Bit 14 flags illegal operation reset.
// R9 - Bit 9 flags configuration mismatch reset.
// R10 - Bit 7 flags master clear pin reset.
// R11 - Bit 6 flags reset instruction executed.
// R12 - Bit 4 flags watchdog time-out.
// R13 - Bit 1 brown-out, bit 0 power-on.
// R14 - Bit 5 enables watchdog unless config forces.
// R15 - Bit 8 keeps core regulator on in sleep.
// R16 - Bit 11 keeps flash regulator on in sleep.
// R17 - Bit 3 sleep flag, bit 2 idle flag.
// R18 - Bits 13, 12, 10 read zero.
// R19 - Software clears status bits after reading them.
// R20 - Non-power-on resets keep other bits.
//
// Our own choices: the register offsets and register access over Wishbone.
`include "rsc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module rsc_combiner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`RSC_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic por_i,
    input wire logic brownout_i,
    input wire logic master_clear_pin_i,
    input wire logic soft_reset_i,
    input wire logic watchdog_timeout_i,
    input wire logic config_mismatch_i,
    input wire logic trap_conflict_i,
    input wire logic illegal_op_i,
    input wire logic sleep_entered_i,
    input wire logic idle_entered_i,
    input wire logic config_watchdog_enable_i,
    input wire logic [2:0] config_clock_select_i,
    input wire logic [2:0] current_clock_select_i,
    output logic master_system_reset_o,
    output logic [2:0] clock_select_o,
    output logic cold_reset_o,
    output logic watchdog_enable_o,
    output logic core_regulator_sleep_active_o,
    output logic flash_regulator_sleep_active_o
);
    // ===================================================
    // Input synchronisers
    // ===================================================
    // Two stages per source; stage one feeds only stage two.
    logic [9:0] raw;
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic [5:0] occ_sync1_q;
    logic [5:0] occ_sync2_q;
    assign raw = {idle_entered_i, sleep_entered_i, illegal_op_i,
                  trap_conflict_i, config_mismatch_i, watchdog_timeout_i,
                  soft_reset_i, master_clear_pin_i, brownout_i, por_i};
    always_ff @(posedge clk_i)
    begin
        sync1_q <= raw;
        sync2_q <= sync1_q;
        occ_sync1_q <= {config_watchdog_enable_i, config_clock_select_i,
                        current_clock_select_i[1:0]};
        occ_sync2_q <= occ_sync1_q;
    end
    logic [2:0] cur_sync1_q;
    logic [2:0] cur_sync2_q;
    // Clock select values are quasi-static, so bitwise sync is enough.
    always_ff @(posedge clk_i)
    begin
        cur_sync1_q <= current_clock_select_i;
        cur_sync2_q <= cur_sync1_q;
    end
    logic s_por, s_bor, s_pin, s_soft, s_watchdog_timeout_flag, s_cm, s_trap, s_ill;
    logic s_sleep, s_idle;
    assign {s_idle, s_sleep, s_ill, s_trap, s_cm, s_watchdog_timeout_flag, s_soft, s_pin,
            s_bor, s_por} = sync2_q;
    // Sleep and idle wake flags are not reset sources, so they are left
    // out of the combine; they only set their cause bits.
    // The extra sync latency is harmless: every source lasts 2+ clocks.
    logic any_src;
    logic cold_src;
    // R1 - any source active
    assign any_src = |sync2_q[7:0];
    // R5 - cold source kinds
    assign cold_src = s_por | s_bor;

    // ===================================================
    // Reset sequencer
    // ===================================================
    // Hold the master reset a few clocks past the last source so short
    // glitches still produce a clean reset.
    rsc_pkg::rsc_state_type state_q;
    logic [3:0] hold_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= rsc_pkg::RSC_HOLD;
            hold_q <= `RSC_RESET_HOLD;
        end
        else
        begin
            case (state_q)
                rsc_pkg::RSC_RUN:
                begin
                    if (any_src)
                    begin
                        state_q <= rsc_pkg::RSC_HOLD;
                        hold_q <= `RSC_RESET_HOLD;
                    end
                end
                rsc_pkg::RSC_HOLD:
                begin
                    if (any_src)
                        hold_q <= `RSC_RESET_HOLD;
                    else if (hold_q == 4'h0)
                        state_q <= rsc_pkg::RSC_RUN;
                    else
                        hold_q <= hold_q - 4'h1;
                end
                default:
                    state_q <= rsc_pkg::RSC_HOLD;
            endcase
        end
    end
    // R1 - drive master reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            master_system_reset_o <= 1'b1;
        else
            master_system_reset_o <= any_src
                || (state_q == rsc_pkg::RSC_HOLD);
    end

    // ===================================================
    // Cold or warm classification and clock choice
    // ===================================================
    // The kind latches while sources are active; rst_i counts as cold.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cold_reset_o <= 1'b1;
        else if (any_src)
            // R5 - cold reset kind
            cold_reset_o <= cold_src;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            clock_select_o <= 3'h0;
        else if (master_system_reset_o && cold_reset_o)
            // R5 - configuration clock select
            clock_select_o <= occ_sync2_q[4:2];
        else if (master_system_reset_o)
            // R6 - current clock select
            clock_select_o <= cur_sync2_q;
    end

    // ===================================================
    // Cause register and Wishbone slave
    // ===================================================
    // One status word; hardware sets bits and power-on clears all but bits one
    // and zero; software may set or clear the implemented bits through the bus.
    logic [15:0] cause_q;
    logic [15:0] hw_set;
    logic wr_cause;
    logic [15:0] wr_val;
    function automatic logic [15:0] rsc_merge(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
            r[7:0] = d[7:0];
        if (sel[1])
            r[15:8] = d[15:8];
        return r;
    endfunction
    always_comb
    begin
        hw_set = 16'h0000;
        // R7 - trap conflict flag
        hw_set[`RSC_BIT_TRAP] = s_trap;
        // R8 - illegal operation flag
        hw_set[`RSC_BIT_ILLOP] = s_ill;
        // R9 - mismatch flag
        hw_set[`RSC_BIT_CM] = s_cm;
        // R10 - pin reset flag
        hw_set[`RSC_BIT_PIN] = s_pin;
        // R11 - soft reset flag
        hw_set[`RSC_BIT_SOFT] = s_soft;
        // R12 - watchdog flag
        hw_set[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = s_watchdog_timeout_flag;
        // R13 - brownout and power-on
        hw_set[`RSC_BIT_BOR] = s_bor;
        hw_set[`RSC_BIT_POR] = s_por;
        // R17 - sleep and idle flags
        hw_set[`RSC_BIT_SLEEP] = s_sleep;
        hw_set[`RSC_BIT_IDLE] = s_idle;
    end
    assign wr_cause = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && (wb_adr_i == `RSC_OFS_CAUSE);
    assign wr_val = rsc_merge(cause_q, wb_dat_i, wb_sel_i);
    // Hardware sets win over a software clear in the same cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || s_por)
            // R3 - power-on value
            cause_q <= `RSC_CAUSE_POR_VAL;
        else if (wr_cause)
            // R4 - software write, R18 - unimplemented masked
            cause_q <= (wr_val | hw_set) & `RSC_CAUSE_IMPL;
        else
            // R2 - set cause bit, R20 - keep others
            cause_q <= cause_q | hw_set;
    end
    // R14 - watchdog enable
    // R15 - core regulator
    // R16 - flash regulator
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            watchdog_enable_o <= 1'b0;
            core_regulator_sleep_active_o <= 1'b0;
            flash_regulator_sleep_active_o <= 1'b0;
        end
        else
        begin
            watchdog_enable_o <= cause_q[`RSC_BIT_WDEN] | occ_sync2_q[5];
            core_regulator_sleep_active_o <= cause_q[`RSC_BIT_CREG];
            flash_regulator_sleep_active_o <= cause_q[`RSC_BIT_FREG];
        end
    end
    // Single-cycle answer; unmapped addresses read zero and ignore writes.
    // The ack low term spaces requests, so a held strobe is taken on every
    // second clock, once per ack pulse, and a held write lands each time.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_adr_i == `RSC_OFS_CAUSE)
                wb_dat_o <= {16'h0000, cause_q};
            else if (wb_adr_i == `RSC_OFS_CLKSEL)
                wb_dat_o <= {28'h0000000, cold_reset_o, clock_select_o};
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end

    // ===================================================
    // Assertions
    // ===================================================
    // A synced source is followed one edge later by the master reset.
    sequence rsc_src_seen;
        any_src;
    endsequence
    sequence rsc_reset_out;
        master_system_reset_o;
    endsequence

    // ===================================================
    // Master reset checks
    // ===================================================
    // R1 - source asserts reset
    a_src_resets: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        rsc_src_seen |=> rsc_reset_out)
        else $error("Source did not assert master reset.");
    // R1 - reset held while stretching
    a_reset_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        state_q == rsc_pkg::RSC_HOLD |=> master_system_reset_o)
        else $error("Master reset dropped during hold.");

    // ===================================================
    // Cause register checks
    // ===================================================
    // R3 - power-on value
    a_por_value: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        s_por |=> cause_q == 16'h0003)
        else $error("Power-on cause value wrong.");
    // R13 - brown-out flag
    a_bor_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        s_bor && !s_por |=> cause_q[`RSC_BIT_BOR])
        else $error("Brown-out flag not set.");
    // R7 - trap conflict flag
    a_trap_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        s_trap && !s_por |=> cause_q[15])
        else $error("Trap flag not set.");
    // R8 - illegal operation flag
    a_illop_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        s_ill && !s_por |=> cause_q[`RSC_BIT_ILLOP])
        else $error("Illegal operation flag not set.");
    // R9 - mismatch flag
    a_cm_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        s_cm && !s_por |=> cause_q[`RSC_BIT_CM])
        else $error("Mismatch flag not set.");
    // R10 - pin reset flag
    a_pin_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        s_pin && !s_por |=> cause_q[`RSC_BIT_PIN])
        else $error("Pin reset flag not set.");
    // R11 - soft reset flag
    a_soft_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        s_soft && !s_por |=> cause_q[`RSC_BIT_SOFT])
        else $error("Soft reset flag not set.");
    // R12 - watchdog flag
    a_watchdog_timeout_flag_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        s_watchdog_timeout_flag && !s_por |=> cause_q[4])
        else $error("Watchdog flag not set.");
    // R17 - sleep flag
    a_sleep_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        s_sleep && !s_por |=> cause_q[`RSC_BIT_SLEEP])
        else $error("Sleep flag not set.");
    // R17 - idle flag
    a_idle_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        s_idle && !s_por |=> cause_q[`RSC_BIT_IDLE])
        else $error("Idle flag not set.");
    // R18 - holes read zero
    a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        cause_q[13] == 1'b0 && cause_q[12] == 1'b0 && cause_q[10] == 1'b0)
        else $error("Unimplemented bit set.");
    // R20 - other bits kept
    a_keep_bits: assert property (@(posedge clk_i) disable iff (rst_i) // R20
        !s_por && !wr_cause |=> (cause_q & $past(cause_q)) == $past(cause_q))
        else $error("Cause bit lost.");
    // R4 - software write lands
    a_sw_write: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        wr_cause && !s_por && hw_set == 16'h0000
            |=> cause_q == ($past(wr_val) & `RSC_CAUSE_IMPL))
        else $error("Software write not stored.");
    // R4 - write never resets
    a_no_sw_reset: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        wr_cause && !any_src && state_q == rsc_pkg::RSC_RUN
            |=> !master_system_reset_o)
        else $error("Software write caused reset.");

    // ===================================================
    // Reset kind, clock choice and control checks
    // ===================================================
    // R5 - reset kind
    a_cold_kind: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        any_src |=> cold_reset_o == $past(cold_src))
        else $error("Reset kind wrong.");
    // R5 - cold clock choice
    a_cold_clock: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        master_system_reset_o && cold_reset_o
            |=> clock_select_o == $past(occ_sync2_q[4:2]))
        else $error("Cold clock choice wrong.");
    // R6 - warm clock choice
    a_warm_clock: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        master_system_reset_o && !cold_reset_o
            |=> clock_select_o == $past(cur_sync2_q))
        else $error("Warm clock choice wrong.");
    // R14 - forced watchdog
    a_wdt_forced: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        occ_sync2_q[5] |=> watchdog_enable_o)
        else $error("Watchdog not forced on.");
    // R14 - soft watchdog enable
    a_wdt_soft: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        1'b1 |=> watchdog_enable_o == ($past(cause_q[`RSC_BIT_WDEN])
            | $past(occ_sync2_q[5])))
        else $error("Watchdog enable wrong.");
    // R15 - core regulator control
    a_core_reg: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        1'b1 |=> core_regulator_sleep_active_o
            == $past(cause_q[`RSC_BIT_CREG]))
        else $error("Core regulator control wrong.");
    // R16 - flash regulator control
    a_flash_reg: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        1'b1 |=> flash_regulator_sleep_active_o
            == $past(cause_q[`RSC_BIT_FREG]))
        else $error("Flash regulator control wrong.");
endmodule // rsc_combiner
`default_nettype wire

// [dv/rsc_source_model.sv]
// Purpose: Model of the reset and wake sources around the combiner.
// Assumes: One source fires at a time on request from the bench.
// Notes: Each pulse lasts three clocks, above the two-clock minimum.
`timescale 1ns/100ps
`default_nettype none
module rsc_source_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic [3:0] which_i,
    output logic [9:0] src_o
);
    logic [1:0] cnt_q;
    // Hold the chosen source high long enough for the two-flop sync.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src_o <= 10'h000;
            cnt_q <= 2'h0;
        end
        else if (fire_i)
        begin
            src_o <= 10'h001 << which_i;
            cnt_q <= 2'h2;
        end
        else if (cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
        else
            src_o <= 10'h000;
    end
endmodule // rsc_source_model
`default_nettype wire

// [dv/reset_source_combiner_tb.sv]
// Purpose: Self-checking bench for the reset source combiner.
// Assumes: Reads are checked from a queue by a separate monitor.
// Notes: Sources fire one by one; flags accumulate between them.
`include "rsc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module reset_source_combiner_tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, which = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, e;
    logic ack, msr, cold, wden, creg, freg, fire = 1'b0, cfg_wd = 1'b0;
    logic [2:0] cfg_sel = 3'h1, cur_sel = 3'h2, sel_o;
    logic [9:0] src;
    logic [31:0] exp_q[$];
    int num_errors = 0, comparisons = 0;
    int bitpos[10] = '{0, 1, 7, 6, 4, 9, 15, 14, 3, 2};
    logic [15:0] cause;
    logic c;

    rsc_source_model src_m (.clk_i(clk), .rst_i(rst), .fire_i(fire),
        .which_i(which), .src_o(src));
    rsc_combiner dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .por_i(src[0]),
        .brownout_i(src[1]), .master_clear_pin_i(src[2]),
        .soft_reset_i(src[3]), .watchdog_timeout_i(src[4]),
        .config_mismatch_i(src[5]), .trap_conflict_i(src[6]),
        .illegal_op_i(src[7]), .sleep_entered_i(src[8]),
        .idle_entered_i(src[9]), .config_watchdog_enable_i(cfg_wd),
        .config_clock_select_i(cfg_sel), .current_clock_select_i(cur_sel),
        .master_system_reset_o(msr), .clock_select_o(sel_o),
        .cold_reset_o(cold), .watchdog_enable_o(wden),
        .core_regulator_sleep_active_o(creg),
        .flash_regulator_sleep_active_o(freg));

    initial forever #5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        comparisons++;
        if (got !== ex)
        begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, ex);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One classic cycle; held until ack is sampled high.
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 50)
        begin
            chk(1'b0, 1'b1);
            give_verdict();
        end
        cyc <= 1'b0; stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] ex);
        exp_q.push_back(ex);
        wb(1'b0, a, 32'h0);
    endtask

    // Wait for the master reset to reach a level, bounded.
    task automatic wait_msr(input logic lvl);
        int n;
        n = 0;
        while (msr !== lvl && n < 40)
        begin
            n++;
            @(posedge clk);
        end
        chk(msr, lvl);
        if (n == 40) give_verdict();
    endtask

    // Monitor: every read answer is matched with the oldest note.
    always @(posedge clk)
        if (ack === 1'b1 && cyc && !we)
            chk(rdat, exp_q.size() ? exp_q.pop_front() : 32'hx);

    initial
    begin
        #50000;
        num_errors++;
        give_verdict();
    end

    // ========================================
    // Main sequence
    initial
    begin
        void'($urandom(32'h35dd56a1));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wait_msr(1'b0);
        rd(`RSC_OFS_CAUSE, 32'h3);
        rd(`RSC_OFS_CLKSEL, {28'h0, 1'b1, cfg_sel});
        wb(1'b1, `RSC_OFS_CAUSE, 32'h0);
        cause = 16'h0;
        for (int i = 1; i <= 10; i++)
        begin
            which <= 4'(i % 10);
            cfg_sel <= 3'($urandom_range(7));
            cur_sel <= 3'($urandom_range(7));
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            cause = (i == 10) ? 16'h3 : cause | (16'h1 << bitpos[i % 10]);
            c = (i % 10) < 2;
            if (i < 8 || i == 10)
            begin
                wait_msr(1'b1);
                wait_msr(1'b0);
                rd(`RSC_OFS_CLKSEL, {28'h0, c, c ? cfg_sel : cur_sel});
            end
            else
                repeat (6) @(posedge clk);
            rd(`RSC_OFS_CAUSE, {16'h0, cause});
        end
        // Software writes: no reset, holes read zero, controls follow.
        e = $urandom & 32'h0000ffff;
        wb(1'b1, `RSC_OFS_CAUSE, e | 32'h8000);
        repeat (3) @(posedge clk);
        chk(msr, 1'b0);
        rd(`RSC_OFS_CAUSE, (e | 32'h8000) & 32'h0000cbff);
        chk({wden, creg, freg}, {e[5], e[8], e[11]});
        wb(1'b1, `RSC_OFS_CAUSE, 32'h0920);
        repeat (2) @(posedge clk);
        chk({wden, creg, freg}, 3'b111);
        wb(1'b1, `RSC_OFS_CAUSE, 32'h0000);
        cfg_wd <= 1'b1;
        repeat (4) @(posedge clk);
        chk(wden, 1'b1);
        cfg_wd <= 1'b0;
        repeat (4) @(posedge clk);
        chk(wden, 1'b0);
        rd(4'h8, 32'h0);
        repeat (2) @(posedge clk);
        give_verdict();
    end
endmodule // reset_source_combiner_tb
`default_nettype wire
